// [pkg/tofcc_pkg.sv]
// Shared constants, types and register map of the calibration and control block
package tofcc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CAL_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_SEQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_COMMAND = 8'h10;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [11:0] CAL_CTRL_RESET = 12'h000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CMD_START_COMBINED = 0;
  localparam int CMD_START_TIME_DIFF = 1;
  localparam int CMD_ABORT = 2;
  localparam int IRQ_CYCLE = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_WIDTH = 2;

  // ----------------------------------------
  // Settling wait in 32kHz clock cycles
  // ----------------------------------------
  localparam logic [7:0] SETTLE_CODE0 = 8'h10;
  localparam logic [7:0] SETTLE_CODE1 = 8'h30;
  localparam logic [7:0] SETTLE_CODE2 = 8'h60;
  localparam logic [7:0] SETTLE_CODE3 = 8'h80;
  localparam logic [7:0] SETTLE_CODE4 = 8'hA8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic monitor_pin_enable;
    logic monitor_output_select;
    logic irq_enable;
    logic event_timing_continue;
    logic per_cycle_irq;
    logic [2:0] settle_code;
    logic [3:0] cal_period;
  } tofcc_cfg_t;

  typedef struct packed {
    logic temperature;
    logic upstream;
  } tofcc_meas_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_REQ, ST_WAIT} tofcc_state_t;
  typedef enum logic [1:0] {PH_UP, PH_DN, PH_TEMP} tofcc_phase_t;

endpackage

// [hw/tofcc_settle_timer.sv]
// Settling wait timer counted in 32kHz clock ticks
`timescale 1ns/1ns
module tofcc_settle_timer
  import tofcc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_start,
  input wire logic [2:0] i_code,
  input wire logic i_tick_32k,
  // Result
  output logic o_done
);

  logic [7:0] remaining;
  wire logic [7:0] target;
  wire logic last_tick;

  // ----------------------------------------
  // Code to tick count
  // ----------------------------------------
  assign target = (i_code == 3'h0) ? SETTLE_CODE0 :
                  (i_code == 3'h1) ? SETTLE_CODE1 :
                  (i_code == 3'h2) ? SETTLE_CODE2 :
                  (i_code == 3'h3) ? SETTLE_CODE3 : SETTLE_CODE4;
  assign last_tick = i_tick_32k && (remaining == 8'h01);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      remaining <= 8'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= last_tick && !i_start;
      if (i_start) begin
        remaining <= target;
      end else if (i_tick_32k && remaining != 8'h00) begin
        remaining <= remaining - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_settle_short: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_start && i_code == 3'h1 |=> remaining == 8'h30)
    else $error("settle code 1 did not load 48");
  a_settle_long: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_start && i_code == 3'h4 |=> remaining == 8'hA8)
    else $error("settle code 4 did not load 168");
  a_settle_expiry: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_done |-> $past(remaining) == 8'h01 && $past(i_tick_32k))
    else $error("settle done without last tick");

endmodule

// [hw/tofcc_irq_bank.sv]
// Sticky interrupt status with mask, cleared by writing one
`timescale 1ns/1ns
module tofcc_irq_bank #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Events and software access
  input wire logic [WIDTH-1:0] i_set,
  input wire logic [WIDTH-1:0] i_clear,
  input wire logic [WIDTH-1:0] i_mask,
  // Results
  output logic [WIDTH-1:0] o_status,
  output logic o_pending
);

  // Set wins over a clear in the same cycle
  wire logic [WIDTH-1:0] next_status = (o_status & ~i_clear) | i_set;

  assign o_pending = |(o_status & i_mask);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_status <= '0;
    end else begin
      o_status <= next_status;
    end
  end

  a_irq_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_set & i_clear) != '0 |=> (o_status & $past(i_set & i_clear)) == $past(i_set & i_clear))
    else $error("event lost against clear");

endmodule

// [hw/tofcc_top.sv]
// Calibration and control register with event-timing sequencer and monitor pin
`timescale 1ns/1ns
// Behaviour
// - Monitor select matters only while the monitor pin enable is one.
// - Select one drives the monitor pin with the live comparator output.
// - Select zero drives the monitor pin with the launch direction.
// - Direction shows high for upstream measurements, low for downstream ones.
// - Interrupt pin is enabled only while interrupt enable bit 9 is set.
// - All unmasked interrupt sources are ORed onto the single interrupt output.
// - Without continue, combined command runs one difference and temperature sequence, stops.
// - Without continue, difference-only command runs one sequence of cycles, then stops.
// - Settling code 000 waits 16 ticks, code 001 waits 48 ticks.
// - Settling codes 010, 011, 100 wait 96, 128, 168 ticks.
module tofcc_top
  import tofcc_pkg::*;
#(
  parameter int TOF_CYCLES = 4,
  parameter int TEMP_CYCLES = 1
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Measurement engine
  input wire logic i_tick_32k,
  input wire logic i_comparator_out,
  input wire logic i_meas_done,
  output logic o_meas_req,
  output tofcc_meas_t o_meas_kind,
  // Device pins
  output logic o_monitor_pin,
  output logic o_monitor_oe,
  output logic o_irq
);

  localparam logic [7:0] TOF_LAST = 8'(TOF_CYCLES - 1);
  localparam logic [7:0] TEMP_LAST = 8'(TEMP_CYCLES - 1);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire logic bus_wr = bus_req & i_wb_we;
  wire logic hit_cfg = i_wb_adr == OFS_CAL_CTRL;
  wire logic hit_irq_status = i_wb_adr == OFS_IRQ_STATUS;
  wire logic hit_irq_mask = i_wb_adr == OFS_IRQ_MASK;
  wire logic hit_seq_status = i_wb_adr == OFS_SEQ_STATUS;
  wire logic hit_command = i_wb_adr == OFS_COMMAND;
  wire logic cmd_wr = bus_wr & hit_command & i_wb_sel[0];

  tofcc_cfg_t cfg;
  logic [IRQ_WIDTH-1:0] irq_mask;
  wire logic [IRQ_WIDTH-1:0] irq_status;
  wire logic irq_pending;

  tofcc_state_t state;
  tofcc_state_t next_state;
  tofcc_phase_t phase;
  tofcc_phase_t next_phase;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic mode_combined;
  logic timer_start;
  logic evt_cycle;
  logic evt_seq;
  logic evt_done;
  wire logic timer_done;

  wire logic busy = state != ST_IDLE;
  wire logic start_combined = cmd_wr & i_wb_dat[CMD_START_COMBINED] & ~busy;
  wire logic start_time_diff = cmd_wr & i_wb_dat[CMD_START_TIME_DIFF] & ~busy;
  wire logic abort = cmd_wr & i_wb_dat[CMD_ABORT];
  wire logic launch_upstream = busy & (phase == PH_UP);

  wire logic [31:0] seq_status_word = {20'h0_0000, cnt, 1'b0, mode_combined, launch_upstream, busy};
  wire logic [31:0] next_rdata =
    hit_cfg ? {20'h0_0000, cfg} :
    hit_irq_status ? {30'h0000_0000, irq_status} :
    hit_irq_mask ? {30'h0000_0000, irq_mask} :
    hit_seq_status ? seq_status_word : 32'h0000_0000;

  wire logic [IRQ_WIDTH-1:0] irq_clear =
    (bus_wr & hit_irq_status & i_wb_sel[0]) ? i_wb_dat[IRQ_WIDTH-1:0] : '0;
  wire logic [IRQ_WIDTH-1:0] irq_set;
  assign irq_set[IRQ_CYCLE] = evt_cycle & cfg.per_cycle_irq;
  assign irq_set[IRQ_DONE] = evt_done;

  // ----------------------------------------
  // Bus answer, one cycle after request
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= (bus_req & ~i_wb_we) ? next_rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg <= CAL_CTRL_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else begin
      if (bus_wr & hit_cfg & i_wb_sel[0]) begin
        cfg[7:0] <= i_wb_dat[7:0];
      end
      if (bus_wr & hit_cfg & i_wb_sel[1]) begin
        cfg[11:8] <= i_wb_dat[11:8];
      end
      if (bus_wr & hit_irq_mask & i_wb_sel[0]) begin
        irq_mask <= i_wb_dat[IRQ_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------
  // Event-timing sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cnt = cnt;
    timer_start = 1'b0;
    evt_cycle = 1'b0;
    evt_seq = 1'b0;
    evt_done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_combined | start_time_diff) begin
          next_state = ST_SETTLE;
          next_phase = PH_UP;
          next_cnt = 8'h00;
          timer_start = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (timer_done) begin
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (i_meas_done) begin
          case (phase)
            PH_UP: begin
              next_phase = PH_DN;
              next_state = ST_REQ;
            end
            PH_DN: begin
              evt_cycle = 1'b1;
              if (cnt != TOF_LAST) begin
                next_cnt = cnt + 8'h01;
                next_phase = PH_UP;
                next_state = ST_SETTLE;
                timer_start = 1'b1;
              end else if (mode_combined) begin
                next_cnt = 8'h00;
                next_phase = PH_TEMP;
                next_state = ST_SETTLE;
                timer_start = 1'b1;
              end else begin
                evt_seq = 1'b1;
              end
            end
            PH_TEMP: begin
              evt_cycle = 1'b1;
              if (cnt != TEMP_LAST) begin
                next_cnt = cnt + 8'h01;
                next_state = ST_SETTLE;
                timer_start = 1'b1;
              end else begin
                evt_seq = 1'b1;
              end
            end
            default: begin
              next_state = ST_IDLE;
            end
          endcase
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (evt_seq) begin
      if (cfg.event_timing_continue) begin
        next_state = ST_SETTLE;
        next_phase = PH_UP;
        next_cnt = 8'h00;
        timer_start = 1'b1;
      end else begin
        next_state = ST_IDLE;
        evt_done = 1'b1;
      end
    end
    if (abort) begin
      next_state = ST_IDLE;
      timer_start = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      phase <= PH_UP;
      cnt <= 8'h00;
      mode_combined <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cnt <= next_cnt;
      if (start_combined | start_time_diff) begin
        mode_combined <= start_combined;
      end
    end
  end

  // ----------------------------------------
  // Measurement request and pins
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_meas_req <= 1'b0;
      o_meas_kind <= '0;
      o_monitor_pin <= 1'b0;
      o_monitor_oe <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_meas_req <= next_state == ST_REQ;
      o_meas_kind <= {next_phase == PH_TEMP, next_phase == PH_UP};
      o_monitor_oe <= cfg.monitor_pin_enable;
      o_monitor_pin <= cfg.monitor_pin_enable &
        (cfg.monitor_output_select ? i_comparator_out : launch_upstream);
      o_irq <= cfg.irq_enable & irq_pending;
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  tofcc_settle_timer u_settle_timer (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_start(timer_start),
    .i_code(cfg.settle_code),
    .i_tick_32k(i_tick_32k),
    .o_done(timer_done)
  );

  tofcc_irq_bank #(
    .WIDTH(IRQ_WIDTH)
  ) u_irq_bank (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_set(irq_set),
    .i_clear(irq_clear),
    .i_mask(irq_mask),
    .o_status(irq_status),
    .o_pending(irq_pending)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_monitor_pin_gate: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !cfg.monitor_pin_enable |=> !o_monitor_oe && !o_monitor_pin)
    else $error("monitor pin active while disabled");
  a_monitor_comparator: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    cfg.monitor_pin_enable && cfg.monitor_output_select |=> o_monitor_pin == $past(i_comparator_out))
    else $error("monitor pin not following comparator");
  a_monitor_upstream: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    cfg.monitor_pin_enable && !cfg.monitor_output_select && o_meas_req && o_meas_kind == 2'b01
    |-> o_monitor_pin)
    else $error("monitor pin low during upstream launch");
  a_monitor_downstream: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    cfg.monitor_pin_enable && !cfg.monitor_output_select && state == ST_WAIT && phase == PH_DN
    ##1 cfg.monitor_pin_enable && !cfg.monitor_output_select |-> !o_monitor_pin)
    else $error("monitor pin high during downstream measurement");
  a_irq_when_enabled: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    cfg.irq_enable && (irq_status & irq_mask) != '0 |=> o_irq)
    else $error("interrupt missing while enabled");
  a_irq_disabled_low: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !cfg.irq_enable |=> !o_irq)
    else $error("interrupt pin asserted while disabled");
  a_irq_source_or: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_irq |-> $past((irq_status & irq_mask) != '0))
    else $error("interrupt without a pending source");
  a_single_sequence: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    evt_seq && !cfg.event_timing_continue && !abort |=> state == ST_IDLE ##1 !o_meas_req)
    else $error("sequence did not stop without continue");
  a_diff_only_no_temp: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    busy && !mode_combined |-> phase != PH_TEMP)
    else $error("difference-only command ran temperature");
  a_cycle_irq_set: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    evt_cycle && cfg.per_cycle_irq |=> irq_status[IRQ_CYCLE])
    else $error("per-cycle status not set");

  c_combined_run: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_meas_req && o_meas_kind.temperature);
  c_continue_restart: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    evt_seq && cfg.event_timing_continue);
  c_irq_raised: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $rose(o_irq));
  c_abort_busy: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    abort && busy);

endmodule

// [tb/tofcc_engine_model.sv]
// Measurement engine model: 32kHz tick source and measurement done answers
`timescale 1ns/1ns
module tofcc_engine_model
  import tofcc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Control from bench
  input wire logic i_tick_en,
  // Requests from device
  input wire logic i_meas_req,
  input wire tofcc_meas_t i_meas_kind,
  // Answers
  output logic o_tick_32k,
  output logic o_meas_done
);
  int div;
  int lat;

  // ----------------------------------------
  // Tick every third cycle, done after 2..6 cycles, temperature 3 more
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div = 0;
      lat = 0;
      o_tick_32k <= 1'b0;
      o_meas_done <= 1'b0;
    end else begin
      o_tick_32k <= 1'b0;
      o_meas_done <= 1'b0;
      if (i_tick_en) begin
        div = (div == 2) ? 0 : div + 1;
        if (div == 0) begin
          o_tick_32k <= 1'b1;
        end
      end
      if (i_meas_req) begin
        lat = 2 + $urandom_range(4, 0) + (i_meas_kind.temperature ? 3 : 0);
      end else if (lat > 0) begin
        lat = lat - 1;
        if (lat == 0) begin
          o_meas_done <= 1'b1;
        end
      end
    end
  end
endmodule

// [tb/tofcc_tb_top.sv]
// Self-checking bench for the calibration and control block
`timescale 1ns/1ns
module tofcc_tb_top
  import tofcc_pkg::*;
;
  localparam int TOFN = 4;
  localparam int TEMPN = 1;
  localparam int LIMIT = 30000;
  localparam logic [7:0] ADRS [6] = '{OFS_CAL_CTRL, OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_SEQ_STATUS, OFS_COMMAND, 8'h14};
  logic clk;
  logic rst_n;
  logic cyc;
  logic stb;
  logic we;
  logic tick_en;
  logic comp;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] rd_val;
  logic ack;
  logic tick;
  logic mreq;
  logic mdone;
  logic mpin;
  logic moe;
  logic irq;
  tofcc_meas_t mkind;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  tofcc_top #(.TOF_CYCLES(TOFN), .TEMP_CYCLES(TEMPN)) tofcc_top_i (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_tick_32k(tick), .i_comparator_out(comp), .i_meas_done(mdone), .o_meas_req(mreq),
    .o_meas_kind(mkind), .o_monitor_pin(mpin), .o_monitor_oe(moe), .o_irq(irq));

  tofcc_engine_model tofcc_engine_model_i (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_tick_en(tick_en), .i_meas_req(mreq),
    .i_meas_kind(mkind), .o_tick_32k(tick), .o_meas_done(mdone));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles >= LIMIT) begin
      fails++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Wishbone classic cycle
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    check("wb_ack", ack, 1);
    rd_val = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    check(nm, rd_val, e);
  endtask

  function automatic int settle_ticks(input logic [2:0] c);
    case (c)
      3'h0: return 16;
      3'h1: return 48;
      3'h2: return 96;
      3'h3: return 128;
      default: return 168;
    endcase
  endfunction

  task automatic wait_req(output int t);
    int n;
    t = 0;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (mreq === 1'b1) break;
      if (tick === 1'b1) t++;
    end
    check("req_seen", mreq, 1);
  endtask

  // ----------------------------------------
  // One event-timing run with its checks
  // ----------------------------------------
  task automatic run_seq(input logic [2:0] code, input logic comb, input logic pc, input logic ien,
                         input logic [1:0] msk);
    int t;
    int nreq;
    logic [1:0] ek;
    logic [1:0] est;
    nreq = 2 * TOFN + (comb ? TEMPN : 0);
    wb(1'b1, OFS_IRQ_MASK, {30'h0000_0000, msk});
    wb(1'b1, OFS_CAL_CTRL, {20'h0_0000, 1'b1, 1'b0, ien, 1'b0, pc, code, 4'($urandom)});
    tick_en <= 1'b0;
    wb(1'b1, OFS_COMMAND, comb ? 32'h0000_0001 : 32'h0000_0002);
    tick_en <= 1'b1;
    for (int i = 0; i < nreq; i++) begin
      wait_req(t);
      if (i == 0) check("settle_ticks", t, settle_ticks(code));
      ek = (i >= 2 * TOFN) ? 2'h2 : ((i % 2) ? 2'h0 : 2'h1);
      check("meas_kind", mkind, ek);
      @(posedge clk);
      @(posedge clk);
      check("monitor_dir", mpin, ek == 2'h1);
    end
    for (t = 0; t < 40; t++) begin
      @(posedge clk);
      if (mreq === 1'b1) check("extra_req", 1, 0);
    end
    est = {1'b1, pc};
    rd_chk("irq_status", OFS_IRQ_STATUS, est);
    check("irq_pin", irq, ien & |(est & msk));
    wb(1'b1, OFS_IRQ_STATUS, 32'h0000_0003);
    rd_chk("irq_clear", OFS_IRQ_STATUS, 0);
    check("irq_idle", irq, 0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    seed = $urandom(32'hf78f_f1c8);
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0000_0000;
    comp = 1'b0;
    tick_en = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("oe_reset", moe, 0);
    check("irq_reset", irq, 0);
    foreach (ADRS[k]) rd_chk("reset_read", ADRS[k], 0);
    v = $urandom;
    wb(1'b1, OFS_CAL_CTRL, v);
    wb(1'b1, 8'h14, ~v);
    rd_chk("cal_ctrl", OFS_CAL_CTRL, v & 32'h0000_0fff);
    wb(1'b1, OFS_CAL_CTRL, 32'h0000_0400);
    comp <= 1'b1;
    repeat (3) @(posedge clk);
    check("monitor_off", mpin, 0);
    check("oe_off", moe, 0);
    wb(1'b1, OFS_CAL_CTRL, 32'h0000_0c00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (i > 0) check("monitor_cmp", mpin, v[0]);
      v[0] = comp;
      comp <= 1'($urandom);
    end
    check("oe_on", moe, 1);
    for (int c = 0; c < 6; c++) begin
      run_seq(3'(c), c % 2 == 1, 1'($urandom), c != 2, (c == 4) ? 2'h3 : 2'(1 + $urandom_range(2, 0)));
    end
    wb(1'b1, OFS_CAL_CTRL, 32'h0000_0900);
    wb(1'b1, OFS_COMMAND, 32'h0000_0002);
    for (int i = 0; i <= 2 * TOFN; i++) wait_req(seed);
    check("continue_kind", mkind, 2'h1);
    wb(1'b0, OFS_SEQ_STATUS, 32'h0000_0000);
    check("run_busy", rd_val[0], 1);
    wb(1'b1, OFS_COMMAND, 32'h0000_0004);
    repeat (40) @(posedge clk);
    rd_chk("abort_status", OFS_IRQ_STATUS, 0);
    wb(1'b0, OFS_SEQ_STATUS, 32'h0000_0000);
    check("abort_busy", rd_val[0], 0);
    complete_run();
  end
endmodule
